// ---- logic/abs_position_transfer_handshake.v ----
// Purpose: Drive-side absolute position transfer and homing logic
// Assumes: Inputs from pins are asynchronous; all but the four status inputs are synchronised here
// Notes: Long timeouts are top-level parameters
`timescale 1ns/1ns
`default_nettype none
`include "abs_xfer_defs.vh"

module abs_position_transfer_handshake #(
	parameter [31:0] tout_cyc = `TOUT_CYC,
	parameter [31:0] base_on_cyc = `BASE_ON_CYC,
	parameter [31:0] ready_cyc = `READY_CYC,
	parameter [31:0] home_hold_cyc = `HOME_HOLD_CYC
) (
	input wire clk,
	input wire rst_b,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire xfer_mode_in,
	input wire xfer_request_in,
	input wire servo_on_in,
	input wire alarm_reset_in,
	input wire emergency_stop_in,
	input wire home_set_in,
	input wire fwd_limit_in,
	input wire rev_limit_in,
	input wire alarm_in,
	input wire cmd_pulse_in,
	input wire cmd_dir_in,
	input wire enc_step_in,
	input wire enc_dir_in,
	input wire in_pos_status_in,
	input wire zero_speed_status_in,
	input wire torque_limit_status_in,
	input wire brake_status_in,
	output wire fault_out,
	output reg in_position_out,
	output reg zero_speed_out,
	output reg torque_limit_out,
	output reg brake_interlock_out,
	output wire xfer_data_ready_out,
	output wire xfer_bit0_out,
	output wire xfer_bit1_out,
	output reg base_on_out,
	output reg ready_out,
	output reg droop_clear_out,
	output reg quick_stop_out,
	output reg home_store_out,
	output reg [31:0] home_pos_out,
	output reg xfer_timeout_warning,
	output reg home_setting_warning
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
localparam NSYNC = 13;
wire [NSYNC-1:0] async_in;
reg [NSYNC-1:0] s1_r;
reg [NSYNC-1:0] s2_r;
assign async_in = {enc_dir_in, enc_step_in, cmd_dir_in, cmd_pulse_in, alarm_in, rev_limit_in, fwd_limit_in,
	home_set_in, emergency_stop_in, alarm_reset_in, servo_on_in, xfer_request_in, xfer_mode_in};
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		s1_r <= {NSYNC{1'b0}};
		s2_r <= {NSYNC{1'b0}};
	end else begin
		s1_r <= async_in;
		s2_r <= s1_r;
	end
end
wire mode_s = s2_r[0];
wire req_s = s2_r[1];
wire son_s = s2_r[2];
wire res_s = s2_r[3];
wire emg_s = s2_r[4];
wire home_s = s2_r[5];
wire limit_s = s2_r[6] | s2_r[7];
wire alarm_s = s2_r[8];
wire cmd_p_s = s2_r[9];
wire cmd_d_s = s2_r[10];
wire enc_p_s = s2_r[11];
wire enc_d_s = s2_r[12];

reg mode_d_r, home_d_r, cmd_d_r, enc_d_r, emg_d_r;
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		mode_d_r <= 1'b0;
		home_d_r <= 1'b0;
		cmd_d_r <= 1'b0;
		enc_d_r <= 1'b0;
		emg_d_r <= 1'b0;
	end else begin
		mode_d_r <= mode_s;
		home_d_r <= home_s;
		cmd_d_r <= cmd_p_s;
		enc_d_r <= enc_p_s;
		emg_d_r <= emg_s;
	end
end
wire mode_rise = mode_s & ~mode_d_r;
wire home_rise = home_s & ~home_d_r;
wire cmd_edge = cmd_p_s & ~cmd_d_r;
wire enc_edge = enc_p_s & ~enc_d_r;
wire emg_fall = ~emg_s & emg_d_r;

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [31:0] ctrl_r;
wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr_ctrl = wb_hit & wb_we_i & (wb_adr_i == `REG_CTRL);
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_ctrl
		always @(posedge clk or negedge rst_b) begin
			if (!rst_b)
				ctrl_r[gi*8 +: 8] <= `CTRL_RST_LANE;
			else if (wr_ctrl && wb_sel_i[gi])
				ctrl_r[gi*8 +: 8] <= wb_dat_i[gi*8 +: 8];
		end
	end
endgenerate
wire dog_mode = ctrl_r[`CTRL_DOG];

////////////////////////////////////////////////////////////////////////////////
// Position tracking and droop
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_READY = 3'h1;
localparam [2:0] ST_REQ = 3'h2;
localparam [2:0] ST_DONE = 3'h3;
localparam [2:0] ST_HOLD = 3'h4;
reg [2:0] state_r;
reg [31:0] pos_r;
reg [31:0] pos_cmd_r;
reg [31:0] latch_r;
wire accept_cmd = ~limit_s;
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		pos_r <= 32'h0000_0000;
		pos_cmd_r <= 32'h0000_0000;
	end else begin
		if (enc_edge)
			pos_r <= enc_d_s ? pos_r - 32'h0000_0001 : pos_r + 32'h0000_0001;
		if (state_r == ST_IDLE && mode_rise && !alarm_s && !ready_out)
			pos_cmd_r <= pos_r;
		else if (droop_clear_out)
			pos_cmd_r <= pos_r;
		else if (cmd_edge && accept_cmd)
			pos_cmd_r <= cmd_d_s ? pos_cmd_r - 32'h0000_0001 : pos_cmd_r + 32'h0000_0001;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Transfer state machine
reg [4:0] step_r;
reg [5:0] csum_r;
reg [1:0] data_r;
reg [31:0] tcnt_r;
reg rdy_r;
wire aborting = ~son_s | res_s | emg_s;
wire [1:0] grp = (step_r < 5'h10) ? latch_r[1:0] : csum_r[1:0];
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		state_r <= ST_IDLE;
		step_r <= 5'h00;
		csum_r <= 6'h00;
		data_r <= 2'h0;
		tcnt_r <= 32'h0000_0000;
		rdy_r <= 1'b0;
		latch_r <= 32'h0000_0000;
		xfer_timeout_warning <= 1'b0;
	end else begin
		tcnt_r <= tcnt_r + 32'h0000_0001;
		case (state_r)
		ST_IDLE: begin
			if (mode_rise && !alarm_s && !ready_out) begin
				xfer_timeout_warning <= 1'b0;
				latch_r <= pos_r;
				csum_r <= 6'h00;
				step_r <= 5'h00;
				tcnt_r <= 32'h0000_0000;
				rdy_r <= 1'b1;
				state_r <= ST_READY;
			end
		end
		ST_READY: begin
			if (!mode_s || (aborting && !emg_s) || (emg_s && step_r == 5'h00 && 1'b0)) begin
				xfer_timeout_warning <= 1'b1;
				rdy_r <= 1'b0;
				state_r <= ST_HOLD;
			end else if (req_s) begin
				data_r <= grp;
				if (step_r < 5'h10) begin
					csum_r <= csum_r + {4'h0, latch_r[1:0]};
					latch_r <= {2'h0, latch_r[31:2]};
				end else
					csum_r <= {2'h0, csum_r[5:2]};
				rdy_r <= 1'b0;
				tcnt_r <= 32'h0000_0000;
				state_r <= ST_REQ;
			end else if (tcnt_r >= tout_cyc) begin
				xfer_timeout_warning <= 1'b1;
				rdy_r <= 1'b0;
				state_r <= ST_HOLD;
			end
		end
		ST_REQ: begin
			if (!mode_s || (aborting && !emg_s)) begin
				xfer_timeout_warning <= 1'b1;
				state_r <= ST_HOLD;
			end else if (!req_s) begin
				step_r <= step_r + 5'h01;
				rdy_r <= 1'b1;
				tcnt_r <= 32'h0000_0000;
				state_r <= (step_r == `STEP_LAST) ? ST_DONE : ST_READY;
			end else if (tcnt_r >= tout_cyc) begin
				xfer_timeout_warning <= 1'b1;
				state_r <= ST_HOLD;
			end
		end
		ST_DONE: begin
			if (!mode_s) begin
				rdy_r <= 1'b0;
				state_r <= ST_IDLE;
			end else if (tcnt_r >= tout_cyc) begin
				xfer_timeout_warning <= 1'b1;
				state_r <= ST_HOLD;
			end
		end
		ST_HOLD: begin
			rdy_r <= 1'b0;
			if (!mode_s)
				state_r <= ST_IDLE;
		end
		default: state_r <= ST_IDLE;
		endcase
		if (state_r != ST_IDLE && state_r != ST_DONE && state_r != ST_HOLD && aborting && !emg_s) begin
			xfer_timeout_warning <= 1'b1;
			rdy_r <= 1'b0;
			state_r <= ST_HOLD;
		end
		if (emg_s && !emg_d_r && state_r != ST_IDLE && state_r != ST_DONE && state_r != ST_HOLD
			&& step_r != 5'h00) begin
			xfer_timeout_warning <= 1'b1;
			rdy_r <= 1'b0;
			state_r <= ST_HOLD;
		end
	end
end
wire xfer_on = mode_s & ~alarm_s;

////////////////////////////////////////////////////////////////////////////////
// Output multiplexing
assign xfer_data_ready_out = xfer_on & rdy_r;
assign xfer_bit0_out = xfer_on & data_r[0];
assign xfer_bit1_out = xfer_on & data_r[1];
assign fault_out = alarm_s;
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		in_position_out <= 1'b0;
		zero_speed_out <= 1'b0;
		torque_limit_out <= 1'b0;
		brake_interlock_out <= 1'b0;
	end else begin
		in_position_out <= xfer_on ? data_r[0] : in_pos_status_in;
		zero_speed_out <= xfer_on ? data_r[1] : zero_speed_status_in;
		torque_limit_out <= xfer_on ? rdy_r : torque_limit_status_in;
		brake_interlock_out <= xfer_on ? data_r[1] : brake_status_in;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Power stage and ready sequencing
reg [31:0] pcnt_r;
reg emg_seen_r;
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		base_on_out <= 1'b0;
		ready_out <= 1'b0;
		pcnt_r <= 32'h0000_0000;
		emg_seen_r <= 1'b0;
	end else begin
		if (emg_fall)
			emg_seen_r <= 1'b1;
		if (emg_s || !son_s || alarm_s || !ctrl_r[`CTRL_ABS_EN] && 1'b0) begin
			base_on_out <= 1'b0;
			ready_out <= 1'b0;
			pcnt_r <= 32'h0000_0000;
			emg_seen_r <= 1'b0;
		end else if (!base_on_out) begin
			if (state_r != ST_IDLE || emg_seen_r) begin
				pcnt_r <= pcnt_r + 32'h0000_0001;
				if ((!emg_seen_r && !emg_fall) || pcnt_r >= base_on_cyc) begin
					base_on_out <= 1'b1;
					pcnt_r <= 32'h0000_0000;
				end
			end
		end else if (!ready_out) begin
			if (mode_s)
				pcnt_r <= ready_cyc;
			else if (pcnt_r >= ready_cyc) begin
				ready_out <= 1'b1;
				emg_seen_r <= 1'b0;
			end else
				pcnt_r <= pcnt_r + 32'h0000_0001;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Homing and stroke end
reg [31:0] hcnt_r;
reg hstored_r;
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		hcnt_r <= 32'h0000_0000;
		hstored_r <= 1'b0;
		home_store_out <= 1'b0;
		home_pos_out <= 32'h0000_0000;
		home_setting_warning <= 1'b0;
		droop_clear_out <= 1'b0;
		quick_stop_out <= 1'b0;
	end else begin
		home_store_out <= 1'b0;
		droop_clear_out <= limit_s;
		quick_stop_out <= limit_s;
		if (!home_s) begin
			hcnt_r <= 32'h0000_0000;
			hstored_r <= 1'b0;
		end else if (!hstored_r)
			hcnt_r <= hcnt_r + 32'h0000_0001;
		if (dog_mode && home_rise) begin
			droop_clear_out <= 1'b1;
			quick_stop_out <= 1'b1;
			if (in_pos_status_in) begin
				home_store_out <= 1'b1;
				home_pos_out <= pos_r;
				home_setting_warning <= 1'b0;
			end else
				home_setting_warning <= 1'b1;
		end
		if (!dog_mode && home_s && !hstored_r && hcnt_r >= home_hold_cyc) begin
			hstored_r <= 1'b1;
			if (!son_s || in_pos_status_in) begin
				home_store_out <= 1'b1;
				home_pos_out <= pos_r;
				home_setting_warning <= 1'b0;
			end else
				home_setting_warning <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Wishbone slave
wire [31:0] stat_w = {26'h0, limit_s, state_r != ST_IDLE, ready_out, base_on_out,
	home_setting_warning, xfer_timeout_warning};
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0000_0000;
	end else begin
		wb_ack_o <= wb_hit;
		if (wb_hit && !wb_we_i) begin
			case (wb_adr_i)
			`REG_CTRL: wb_dat_o <= ctrl_r;
			`REG_STAT: wb_dat_o <= stat_w;
			`REG_POS: wb_dat_o <= pos_r;
			`REG_HOME: wb_dat_o <= home_pos_out;
			default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
end

endmodule // abs_position_transfer_handshake
`default_nettype wire

// ---- logic/abs_xfer_defs.vh ----
// Purpose: Constants for the absolute position transfer block
// Assumes: 100 MHz clock, 32-bit Wishbone slave
// Notes: Summary list below
//
// Summary of operation
// - Send 32 position bits then 6-bit checksum
// - Checksum sums every two-bit position group
// - Mode rising edge clears timeout warning, only while idle with ready output low
// - Request must rise within 5 s
// - Request must fall within 5 s
// - Mode must drop 5 s after last ready
// - Early mode drop aborts, raises warning
// - Servo off, reset abort transfer outside stop; stop onset aborts after first step
// - Mode ignored during alarm; controller drops servo
// - Power stage on 95 ms after stop release
// - Ready 5 ms after power with mode off; at once on mode drop if mode was on
// - Position tracked; latched and loaded on mode
// - Mode accepted in emergency stop
// - Dog homing: clear droop, stop, store home
// - Home set without in-position raises warning
// - Data-set homing stores after 20 ms hold
// - Data-set homing allowed with servo off
// - Brake interlock output carries bit 1
// - Stroke end blocks pulses, clears droop
// - Mode edge computes position, raises ready
// - Request presents two bits, drops ready
// - Mode repurposes in-position, zero-speed, torque-limit
`ifndef ABS_XFER_DEFS_VH
`define ABS_XFER_DEFS_VH

`define CLK_MHZ 100
`define TOUT_MS 5000
`define TOUT_CYC (`TOUT_MS * 1000 * `CLK_MHZ)
`define BASE_ON_MS 95
`define BASE_ON_CYC (`BASE_ON_MS * 1000 * `CLK_MHZ)
`define READY_MS 5
`define READY_CYC (`READY_MS * 1000 * `CLK_MHZ)
`define HOME_HOLD_MS 20
`define HOME_HOLD_CYC (`HOME_HOLD_MS * 1000 * `CLK_MHZ)
`define STEP_LAST 5'h12

`define REG_CTRL 4'h0
`define REG_STAT 4'h4
`define REG_POS 4'h8
`define REG_HOME 4'hC

`define CTRL_DOG 0
`define CTRL_ABS_EN 1
`define CTRL_RST_LANE 8'h00

`define STAT_TOUT 0
`define STAT_HWARN 1
`define STAT_BASE 2
`define STAT_READY 3
`define STAT_XFER 4
`define STAT_LIMIT 5

`endif

// ---- tb/abs_xfer_chk_properties.sv ----
// Purpose: Port checks for the position transfer block
// Assumes: Shortened timeout parameter handed on by the bind
// Notes: Bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module abs_xfer_chk #(parameter [31:0] tout_cyc = 32'h0000_00C8) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic xfer_mode_in,
	input wire logic xfer_request_in,
	input wire logic xfer_data_ready_out,
	input wire logic xfer_bit1_out,
	input wire logic brake_interlock_out,
	input wire logic fault_out,
	input wire logic ready_out,
	input wire logic xfer_timeout_warning,
	input wire logic fwd_limit_in,
	input wire logic rev_limit_in,
	input wire logic droop_clear_out,
	input wire logic quick_stop_out
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_b);
logic [31:0] rdy_wait;
always_ff @(posedge clk or negedge rst_b) begin
	if (!rst_b)
		rdy_wait <= '0;
	else
		rdy_wait <= (xfer_data_ready_out && !xfer_request_in && !xfer_timeout_warning) ? rdy_wait + 1 : '0;
end
////////////////////////////////////////
sequence s_req_up; $rose(xfer_request_in) && xfer_data_ready_out; endsequence
sequence s_rdy_drop; ##[1:5] !xfer_data_ready_out; endsequence
sequence s_req_down; $fell(xfer_request_in) && xfer_mode_in && !xfer_timeout_warning; endsequence
sequence s_rdy_up; ##[1:5] xfer_data_ready_out; endsequence
property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
property p_step; s_req_up |-> s_rdy_drop; endproperty
property p_rise; s_req_down |-> s_rdy_up; endproperty
property p_tout; rdy_wait <= tout_cyc + 4; endproperty
property p_clr; $rose(xfer_mode_in) && !fault_out && !ready_out |-> ##[2:5] !xfer_timeout_warning; endproperty
property p_brake; xfer_data_ready_out [*3] |-> brake_interlock_out == xfer_bit1_out; endproperty
property p_limit; (fwd_limit_in || rev_limit_in) [*5] |-> droop_clear_out && quick_stop_out; endproperty
a_ack: assert property (p_ack) else $error("no ack after request");
a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
a_step: assert property (p_step) else $error("data ready kept after request");
a_rise: assert property (p_rise) else $error("data ready not back after request drop");
a_tout: assert property (p_tout) else $error("request wait not timed out");
a_clr: assert property (p_clr) else $error("warning kept after mode rise");
a_brake: assert property (p_brake) else $error("brake output not bit 1");
a_limit: assert property (p_limit) else $error("limit without droop clear and stop");
endmodule // abs_xfer_chk
bind abs_position_transfer_handshake abs_xfer_chk #(.tout_cyc(tout_cyc)) u_chk (
	.clk(clk),
	.rst_b(rst_b),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.xfer_mode_in(xfer_mode_in),
	.xfer_request_in(xfer_request_in),
	.xfer_data_ready_out(xfer_data_ready_out),
	.xfer_bit1_out(xfer_bit1_out),
	.brake_interlock_out(brake_interlock_out),
	.fault_out(fault_out),
	.ready_out(ready_out),
	.xfer_timeout_warning(xfer_timeout_warning),
	.fwd_limit_in(fwd_limit_in),
	.rev_limit_in(rev_limit_in),
	.droop_clear_out(droop_clear_out),
	.quick_stop_out(quick_stop_out)
);
`default_nettype wire

// ---- tb/ctrl_model.sv ----
// Purpose: Controller side of the position handshake
// Assumes: go held for the whole transfer
// Notes: stall withholds requests
`timescale 1ns/1ns
`default_nettype none
module ctrl_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic go,
	input wire logic stall,
	input wire logic rdy,
	input wire logic b0,
	input wire logic b1,
	output logic mode,
	output logic req,
	output logic [31:0] pos,
	output logic [5:0] ck,
	output logic [5:0] acc,
	output logic [4:0] steps,
	output logic csum_err,
	output logic pos_valid
);
assign csum_err = (steps == 5'h13) && (acc != ck);
assign pos_valid = (steps == 5'h13) && (acc == ck);
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		mode <= 1'b0;
		req <= 1'b0;
		pos <= 32'h0;
		ck <= 6'h0;
		acc <= 6'h0;
		steps <= 5'h0;
	end else begin
		mode <= go && !csum_err;
		if (!mode) begin
			steps <= 5'h0;
			acc <= 6'h0;
			req <= 1'b0;
		end else if (!req && rdy && !stall && steps < 5'h13)
			req <= 1'b1;
		else if (req && !rdy) begin
			if (steps < 5'h10) begin
				pos[2*steps +: 2] <= {b1, b0};
				acc <= acc + {4'h0, b1, b0};
			end else
				ck[2*(steps-16) +: 2] <= {b1, b0};
			steps <= steps + 5'h1;
			req <= 1'b0;
		end
	end
end
endmodule // ctrl_model
`default_nettype wire

// ---- tb/abs_position_transfer_handshake_tb.sv ----
// Purpose: Self-checking bench for the position transfer block
// Assumes: Shortened counts through parameters
// Notes: Controller model drives mode and request
`timescale 1ns/1ns
`default_nettype none
module abs_position_transfer_handshake_tb;
logic clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, servo_on_in, alarm_reset_in, home_set_in, fwd_limit_in;
logic rev_limit_in, alarm_in, enc_step_in, enc_dir_in, in_pos_status_in, brake_status_in, go, stall;
logic emergency_stop_in, cmd_pulse_in, cmd_dir_in, zero_speed_status_in, torque_limit_status_in;
logic wb_ack_o, fault_out, in_position_out, zero_speed_out, torque_limit_out, brake_interlock_out;
logic xfer_data_ready_out, xfer_bit0_out, xfer_bit1_out, base_on_out, ready_out, droop_clear_out;
logic quick_stop_out, home_store_out, xfer_timeout_warning, home_setting_warning, xfer_mode_in, xfer_request_in;
logic [3:0] wb_adr_i, wb_sel_i;
logic [31:0] wb_dat_i, wb_dat_o, home_pos_out, pos, q;
logic [5:0] ck, acc;
logic csum_err, pos_valid;
logic [4:0] steps;
int n_fail, num_checks, cyc_n;
abs_position_transfer_handshake #(.tout_cyc(200), .base_on_cyc(50), .ready_cyc(20), .home_hold_cyc(10)) DUT (.*);
ctrl_model u_ctrl (.clk, .rst_b, .go, .stall, .rdy(xfer_data_ready_out), .b0(xfer_bit0_out),
	.b1(xfer_bit1_out), .mode(xfer_mode_in), .req(xfer_request_in), .pos, .ck, .acc, .steps, .csum_err,
	.pos_valid);
////////////////////////////////////////
task close_out;
	$display("checks %0d errors %0d", num_checks, n_fail);
	if (n_fail == 0 && num_checks > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
	num_checks++;
	if (got !== exp) begin
		n_fail++;
		$display("wrong value at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task nc(input int n);
	repeat (n) @(posedge clk);
endtask
task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
	@(posedge clk);
	wb_cyc_i <= 1'b1;
	wb_stb_i <= 1'b1;
	wb_we_i <= w;
	wb_adr_i <= a;
	wb_dat_i <= d;
	do @(posedge clk); while (wb_ack_o !== 1'b1);
	q = wb_dat_o;
	wb_cyc_i <= 1'b0;
	wb_stb_i <= 1'b0;
endtask
task t_regs;
	brake_status_in <= 1'b1;
	wb(1'b0, 4'h0, 32'h0);
	chk(q, 32'h0);
	wb(1'b1, 4'h0, 32'h2);
	wb(1'b0, 4'h0, 32'h0);
	chk(q, 32'h2);
	wb(1'b0, 4'h2, 32'h0);
	chk(q, 32'h0);
	chk(brake_interlock_out, 1'b1);
endtask
task t_move;
	enc_dir_in <= 1'b1;
	repeat (10) begin
		nc(2);
		enc_step_in <= 1'b1;
		nc(2);
		enc_step_in <= 1'b0;
	end
	nc(4);
	wb(1'b0, 4'h8, 32'h0);
	chk(q, 32'hFFFF_FFF6);
endtask
task t_stall;
	int t0;
	t0 = cyc_n;
	servo_on_in <= 1'b1;
	stall <= 1'b1;
	go <= 1'b1;
	while (xfer_timeout_warning !== 1'b1) @(posedge clk);
	chk(cyc_n - t0 > 200 && cyc_n - t0 < 215, 1'b1);
	wb(1'b0, 4'h4, 32'h0);
	chk(q[0], 1'b1);
	go <= 1'b0;
	stall <= 1'b0;
	nc(6);
	chk(ready_out, 1'b1);
	servo_on_in <= 1'b0;
	nc(4);
	servo_on_in <= 1'b1;
	nc(4);
endtask
task t_abort;
	go <= 1'b1;
	while (steps !== 5'h3) @(posedge clk);
	chk(xfer_timeout_warning, 1'b0);
	go <= 1'b0;
	nc(8);
	chk(xfer_timeout_warning, 1'b1);
endtask
task t_alarm;
	alarm_in <= 1'b1;
	nc(4);
	go <= 1'b1;
	nc(30);
	chk(xfer_data_ready_out, 1'b0);
	chk(fault_out, 1'b1);
	wb(1'b0, 4'h4, 32'h0);
	chk(q[4], 1'b0);
	go <= 1'b0;
	alarm_in <= 1'b0;
	alarm_reset_in <= 1'b1;
	nc(4);
	alarm_reset_in <= 1'b0;
	nc(4);
endtask
task t_xfer;
	int t0;
	servo_on_in <= 1'b1;
	go <= 1'b1;
	while (steps !== 5'h13) @(posedge clk);
	nc(4);
	chk(pos, 32'hFFFF_FFF6);
	chk(ck, 6'h2D);
	chk(csum_err, 1'b0);
	chk(pos_valid, 1'b1);
	chk(xfer_data_ready_out, 1'b1);
	chk(base_on_out, 1'b1);
	nc(210);
	chk(xfer_timeout_warning, 1'b1);
	go <= 1'b0;
	t0 = cyc_n;
	while (ready_out !== 1'b1) @(posedge clk);
	chk(cyc_n - t0 < 30, 1'b1);
endtask
task t_emg;
	int t0;
	emergency_stop_in <= 1'b1;
	nc(4);
	chk(base_on_out || ready_out, 1'b0);
	go <= 1'b1;
	while (steps !== 5'h5) @(posedge clk);
	emergency_stop_in <= 1'b0;
	t0 = cyc_n;
	while (base_on_out !== 1'b1) @(posedge clk);
	chk(cyc_n - t0 > 50 && cyc_n - t0 < 60, 1'b1);
	chk(ready_out, 1'b0);
	while (steps !== 5'h13) @(posedge clk);
	chk(pos, 32'hFFFF_FFF6);
	chk(ck, 6'h2D);
	go <= 1'b0;
	while (ready_out !== 1'b1) @(posedge clk);
endtask
task t_home;
	int t0;
	home_set_in <= 1'b1;
	nc(15);
	home_set_in <= 1'b0;
	nc(6);
	chk(home_setting_warning, 1'b1);
	servo_on_in <= 1'b0;
	nc(4);
	home_set_in <= 1'b1;
	t0 = cyc_n;
	while (home_store_out !== 1'b1) @(posedge clk);
	chk(cyc_n - t0 > 10, 1'b1);
	nc(2);
	chk(home_pos_out, 32'hFFFF_FFF6);
	chk(home_setting_warning, 1'b0);
	home_set_in <= 1'b0;
	wb(1'b1, 4'h0, 32'h3);
	in_pos_status_in <= 1'b1;
	home_set_in <= 1'b1;
	while (home_store_out !== 1'b1) @(posedge clk);
	chk(droop_clear_out && quick_stop_out, 1'b1);
	home_set_in <= 1'b0;
	wb(1'b0, 4'hC, 32'h0);
	chk(q, 32'hFFFF_FFF6);
endtask
task t_limit;
	for (int k = 0; k < 2; k++) begin
		fwd_limit_in <= (k == 0);
		rev_limit_in <= (k == 1);
		nc(6);
		chk(droop_clear_out && quick_stop_out, 1'b1);
	end
	fwd_limit_in <= 1'b0;
	rev_limit_in <= 1'b0;
endtask
initial begin
	clk = 1'b0;
	forever #5 clk = ~clk;
end
always @(posedge clk) begin
	cyc_n++;
	if (cyc_n == 6000) begin
		n_fail++;
		close_out;
	end
end
initial begin
	{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, servo_on_in, alarm_reset_in, home_set_in} = '0;
	{fwd_limit_in, rev_limit_in, alarm_in, enc_step_in, enc_dir_in, in_pos_status_in, brake_status_in} = '0;
	{go, stall, emergency_stop_in, cmd_pulse_in, cmd_dir_in, zero_speed_status_in, torque_limit_status_in} = '0;
	rst_b = 1'b0;
	repeat (12) @(posedge clk);
	rst_b <= 1'b1;
	wb_sel_i <= 4'hF;
	nc(3);
	t_regs;
	t_move;
	t_stall;
	t_abort;
	t_alarm;
	t_xfer;
	t_emg;
	t_home;
	t_limit;
	close_out;
end
endmodule // abs_position_transfer_handshake_tb
`default_nettype wire
